// *** pkg/ctl_port_pkg.sv ***
// Purpose: shared constants and types for the two-wire control-port target
// Assumes: system clock of 125 MHz
// Notes:   register space reached through a generic register-file port
package ctl_port_pkg;
	localparam logic [3:0]  ADDR_FIXED_NIBBLE = 4'h2;
	localparam int          CLK_MHZ           = 125;
	localparam int          LATCH_WAIT_US     = 2000;
	localparam int          LATCH_WAIT_MCLK   = 3000;
	localparam int          MCLK_MHZ_DEFAULT  = 12;
	localparam int          LATCH_WAIT_CYCLES = LATCH_WAIT_US * CLK_MHZ
		+ (LATCH_WAIT_MCLK * CLK_MHZ + MCLK_MHZ_DEFAULT - 1) / MCLK_MHZ_DEFAULT;
	localparam int          PTR_STEP_BIT      = 7;
	localparam logic [2:0]  BIT_LAST          = 3'h7;
	localparam logic [2:0]  BIT_FIRST         = 3'h0;
	localparam logic [6:0]  PTR_ONE           = 7'h01;

	typedef struct packed {
		logic       pointer_auto_step;
		logic [6:0] index;
	} reg_pointer_type;

	typedef struct packed {
		logic       write_strobe;
		logic [6:0] index;
		logic [7:0] data;
	} reg_write_type;
endpackage : ctl_port_pkg

// *** verilog/codec_i2c_control_port.sv ***
// Purpose: two-wire control-port target giving a bus master access to configuration registers
// Assumes: scl/sda are asynchronous to clk_i; sda open drain; registers live outside behind reg_* ports
// Notes:   address latched once the post-reset wait has elapsed
module codec_i2c_control_port
	import ctl_port_pkg::*;
#(
	parameter int LATCH_CYCLES = LATCH_WAIT_CYCLES
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	input  wire logic [2:0]           addr_select_pins_i,
	input  wire logic [7:0]           reg_rdata_i,
	output logic [6:0]                reg_rindex_o,
	output reg_write_type             reg_write_o,
	output logic                      ready_o
);
	typedef enum {IDLE, ADDR, ADDR_ACK, PTR, PTR_ACK, WDATA, WDATA_ACK, RDATA, RDATA_ACK} state_type;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage read only by the second
	logic [1:0] scl_sync, sda_sync;
	logic       scl_d, sda_d;
	logic [2:0] sel_meta, sel_sync; // strap pins are pins too: two stages before the latch
	always_ff @(posedge clk_i) begin
		scl_sync <= {scl_sync[0], scl_i};
		sda_sync <= {sda_sync[0], sda_i};
		sel_meta <= addr_select_pins_i;
		sel_sync <= sel_meta;
		scl_d    <= scl_sync[1];
		sda_d    <= sda_sync[1];
	end
	wire scl_s   = scl_sync[1];
	wire sda_s   = sda_sync[1];
	wire scl_up  = scl_s & ~scl_d;
	wire scl_dn  = ~scl_s & scl_d;
	wire start_c = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c  = scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////////////
	// address latch after the reset wait
	logic [31:0] wait_cnt, next_wait_cnt;
	logic        ready, next_ready;
	logic [2:0]  low_addr, next_low_addr;
	always_comb begin
		next_wait_cnt = wait_cnt;
		next_ready    = ready;
		next_low_addr = low_addr;
		if (!ready) begin
			if (wait_cnt >= 32'(LATCH_CYCLES - 1)) begin
				next_ready    = 1'b1;
				next_low_addr = sel_sync;
			end else begin
				next_wait_cnt = wait_cnt + 32'h1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wait_cnt <= 32'h0;
			ready    <= 1'b0;
			low_addr <= 3'h0;
		end else begin
			wait_cnt <= next_wait_cnt;
			ready    <= next_ready;
			low_addr <= next_low_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus target engine
	state_type       state, next_state;
	logic [2:0]      bit_cnt, next_bit_cnt;
	logic [7:0]      shift, next_shift;
	reg_pointer_type ptr, next_ptr;
	logic            sda_drv, next_sda_drv;
	reg_write_type   wr, next_wr;
	logic            full, next_full; // eight bits in; bit_cnt alone cannot tell empty from full

	function automatic logic [6:0] stepped(input reg_pointer_type p);
		stepped = p.pointer_auto_step ? p.index + PTR_ONE : p.index;
	endfunction : stepped

	always_comb begin
		next_state       = state;
		next_bit_cnt     = bit_cnt;
		next_shift       = shift;
		next_ptr         = ptr; // kept across stop/start
		next_sda_drv     = sda_drv;
		next_wr          = wr;
		next_wr.write_strobe = 1'b0;
		next_full        = full;
		if (stop_c || !ready) begin // ignore traffic until latched
			next_state   = IDLE;
			next_sda_drv = 1'b0;
			next_full    = 1'b0;
		end else if (start_c) begin
			next_state   = ADDR;
			next_bit_cnt = BIT_FIRST;
			next_sda_drv = 1'b0;
			next_full    = 1'b0;
		end else begin
			unique case (state)
				IDLE: ;
				ADDR, PTR, WDATA: if (scl_up) begin
					next_shift   = {shift[6:0], sda_s};
					next_bit_cnt = bit_cnt + 3'h1;
					next_full    = (bit_cnt == BIT_LAST);
				end else if (scl_dn && full) begin
					// eighth bit taken on the previous rise; decide ack now
					next_full = 1'b0;
					if (state == ADDR) begin
						if (shift[7:1] == {ADDR_FIXED_NIBBLE, low_addr}) begin
							next_state   = ADDR_ACK;
							next_sda_drv = 1'b1;
						end else begin
							next_state = IDLE;
						end
					end else if (state == PTR) begin
						next_ptr     = shift;
						next_state   = PTR_ACK;
						next_sda_drv = 1'b1;
					end else begin
						next_wr.write_strobe = 1'b1;
						next_wr.index        = ptr.index;
						next_wr.data         = shift;
						next_ptr.index       = stepped(ptr);
						next_state           = WDATA_ACK;
						next_sda_drv         = 1'b1;
					end
				end
				ADDR_ACK: if (scl_dn) begin
					if (shift[0]) begin
						next_state   = RDATA;
						next_shift   = reg_rdata_i;
						next_sda_drv = ~reg_rdata_i[7];
						next_bit_cnt = BIT_FIRST;
					end else begin
						next_state   = PTR;
						next_sda_drv = 1'b0;
						next_bit_cnt = BIT_FIRST;
					end
				end
				PTR_ACK, WDATA_ACK: if (scl_dn) begin
					next_state   = WDATA;
					next_sda_drv = 1'b0;
					next_bit_cnt = BIT_FIRST;
				end
				RDATA: if (scl_dn) begin
					if (bit_cnt == BIT_LAST) begin
						next_state     = RDATA_ACK;
						next_sda_drv   = 1'b0; // release for master ack
						next_ptr.index = stepped(ptr);
					end else begin
						next_shift   = {shift[6:0], 1'b0};
						next_sda_drv = ~shift[6];
						next_bit_cnt = bit_cnt + 3'h1;
					end
				end
				RDATA_ACK: if (scl_up && sda_s) begin
					next_state = IDLE; // nack ends the read
				end else if (scl_dn) begin
					// still here at the fall: master acked, present the next register
					next_state   = RDATA;
					next_shift   = reg_rdata_i;
					next_sda_drv = ~reg_rdata_i[7];
					next_bit_cnt = BIT_FIRST;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state   <= IDLE;
			bit_cnt <= 3'h0;
			shift   <= 8'h0;
			ptr     <= '0;
			sda_drv <= 1'b0;
			wr      <= '0;
			full    <= 1'b0;
		end else begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			shift   <= next_shift;
			ptr     <= next_ptr;
			sda_drv <= next_sda_drv;
			wr      <= next_wr;
			full    <= next_full;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all registered
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sda_o        <= 1'b1;
			sda_oe_o     <= 1'b0;
			reg_rindex_o <= 7'h0;
			reg_write_o  <= '0;
			ready_o      <= 1'b0;
		end else begin
			sda_o        <= 1'b0; // open drain: only ever pulls low
			sda_oe_o     <= next_sda_drv;
			reg_rindex_o <= next_ptr.index;
			reg_write_o  <= next_wr;
			ready_o      <= next_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_no_drive_early: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!ready |-> !sda_oe_o) else $error("sda driven before address latched");
	a_stop_releases: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		stop_c |=> ##1 !sda_oe_o) else $error("sda still driven after stop");
	a_ptr_kept_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(stop_c || start_c) |=> ptr == $past(ptr)) else $error("pointer changed at stop or start");
	a_write_steps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		wr.write_strobe |-> ptr.index == (ptr.pointer_auto_step ? wr.index + PTR_ONE : wr.index))
		else $error("pointer step wrong after write");
	a_ready_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(ready) |-> low_addr == $past(sel_sync)) else $error("address pins not captured");
	a_ready_stays: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ready |=> ready) else $error("ready dropped");
	a_ack_on_match: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state == ADDR_ACK |-> shift[7:1] == {ADDR_FIXED_NIBBLE, low_addr}) else $error("ack on wrong address");
	a_ack_drives: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state == PTR_ACK || state == WDATA_ACK) |-> sda_drv) else $error("received byte not acked");
	a_read_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state == RDATA_ACK |-> !sda_drv) else $error("sda held during master ack");
endmodule : codec_i2c_control_port

// *** dv/bus_master_model.sv ***
// Purpose: two-wire bus master model facing the control-port target
// Assumes: sda has a pull-up, bus clock period 64 ns
// Notes:   scl rests high between frames
module bus_master_model (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'b1; // both lines static while idle
		sda_low_o = 1'b0;
	end
	task automatic start_cond;
		sda_low_o = 1'b0;
		#24 scl_o = 1'b1;
		#16 sda_low_o = 1'b1; // sda falls while scl high
		#16 scl_o = 1'b0;
	endtask : start_cond
	task automatic stop_cond;
		#24 sda_low_o = 1'b1;
		#8 scl_o = 1'b1;
		#16 sda_low_o = 1'b0; // sda rises while scl high
		#32;
	endtask : stop_cond
	task automatic bus_bit(input logic b, output logic r);
		#24 sda_low_o = !b; // data moves only while scl low
		#8 scl_o = 1'b1;
		#16 r = sda_i;
		#16 scl_o = 1'b0;
	endtask : bus_bit
	// msb first, then ack level a on the ninth clock
	task automatic bus_byte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bus_bit(d[i], q[i]);
		end
		bus_bit(a, k);
	endtask : bus_byte
endmodule : bus_master_model

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the control-port target
// Assumes: register file modelled here, strap pins at 3'h5 until t_addr moves them to 3'h2
// Notes:   short post-reset wait so the run stays small
module tb_top
	import ctl_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         LATCH = 200;
	localparam logic [7:0] AW    = {ADDR_FIXED_NIBBLE, 3'h5, 1'b0};
	localparam logic [7:0] AR    = {ADDR_FIXED_NIBBLE, 3'h5, 1'b1};
	logic          clk     = 1'b0;
	logic          reset_n = 1'b0;
	logic [2:0]    strap   = 3'h5;
	logic [7:0]    regs [128];
	logic          scl;
	logic          m_low;
	logic          sda_o;
	logic          sda_oe;
	logic          ready;
	logic [6:0]    rindex;
	reg_write_type wr;
	logic          sda;
	int            n_errors   = 0;
	int            n_compared = 0;
	int            cyc        = 0;
	int            since      = 0;
	// pull-up unless someone pulls low
	assign sda = !m_low & (sda_oe ? sda_o : 1'b1);
	always #4 clk = ~clk;
	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
	end
	always @(posedge clk) begin
		if (wr.write_strobe) regs[wr.index] <= wr.data;
		since <= reset_n ? since + 1 : 0;
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	codec_i2c_control_port #(.LATCH_CYCLES(LATCH)) i_dut (
		.clk_i(clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.addr_select_pins_i(strap), .reg_rdata_i(regs[rindex]), .reg_rindex_o(rindex),
		.reg_write_o(wr), .ready_o(ready));
	bus_master_model i_master (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic send(input logic [7:0] d, input logic ack);
		logic [7:0] q;
		logic       k;
		i_master.bus_byte(d, 1'b1, q, k);
		check({7'h00, k}, {7'h00, ack}, "ack");
	endtask : send
	task automatic get(input logic a, input logic [7:0] exp);
		logic [7:0] q;
		logic       k;
		i_master.bus_byte(8'hff, a, q, k);
		check(q, exp, "read data");
	endtask : get
	task automatic frame(input logic [7:0] d, input logic ack);
		i_master.start_cond();
		send(d, ack);
	endtask : frame
	task automatic point(input logic [7:0] p);
		frame(AW, 1'b0);
		send(p, 1'b0);
		i_master.stop_cond();
	endtask : point
	task automatic t_early;
		frame(AW, 1'b1); // ignored before the address latches
		i_master.stop_cond();
		while (ready !== 1'b1) @(negedge clk);
		check(8'(since), 8'(LATCH), "latch delay");
	endtask : t_early
	task automatic t_addr;
		@(negedge clk) strap = 3'h2;
		frame({ADDR_FIXED_NIBBLE, 3'h2, 1'b0}, 1'b1); // strap read only once, when the post-reset wait ends
		i_master.stop_cond();
		frame({4'h3, 3'h5, 1'b0}, 1'b1); // wrong fixed nibble
		i_master.stop_cond();
	endtask : t_addr
	task automatic t_write;
		frame(AW, 1'b0);
		send(8'h83, 1'b0);
		send(8'ha1, 1'b0);
		send(8'hb2, 1'b0);
		i_master.stop_cond();
		check(regs[3], 8'ha1, "step write 0");
		check(regs[4], 8'hb2, "step write 1");
		frame(AW, 1'b0);
		send(8'h10, 1'b0);
		send(8'h11, 1'b0);
		send(8'h22, 1'b0);
		i_master.stop_cond();
		check(regs[16], 8'h22, "fixed write");
		check(regs[17], 8'h00, "fixed neighbour");
	endtask : t_write
	task automatic t_read;
		point(8'h83);
		frame(AR, 1'b0); // pointer kept across stop
		get(1'b0, 8'ha1);
		get(1'b1, 8'hb2); // stepped read
		i_master.stop_cond();
		point(8'h10);
		frame(AR, 1'b0);
		get(1'b0, 8'h22);
		get(1'b1, 8'h22); // fixed read
		i_master.stop_cond();
	endtask : t_read
	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		t_early();
		t_addr();
		t_write();
		t_read();
		results();
	end
endmodule : tb_top
